// [rtl/scrb_regs.svh]
// register numbers, field masks and reset values of the control bank
// assumes: included by the field register and bank modules by bare name
`ifndef SCRB_REGS_SVH
`define SCRB_REGS_SVH

`define SCRB_NUM_TLB_INDEX 5'h00
`define SCRB_NUM_TLB_RANDOM 5'h01
`define SCRB_NUM_ENTRY_LOW_EVEN 5'h02
`define SCRB_NUM_ENTRY_LOW_ODD 5'h03
`define SCRB_NUM_PAGE_TABLE_PTR 5'h04
`define SCRB_NUM_PAGE_SIZE_MASK 5'h05
`define SCRB_NUM_FIXED_ENTRY_CNT 5'h06
`define SCRB_NUM_FAULTING_ADDR 5'h08
`define SCRB_NUM_CYCLE_COUNTER 5'h09
`define SCRB_NUM_ENTRY_HIGH 5'h0a
`define SCRB_NUM_TIMER_MATCH 5'h0b
`define SCRB_NUM_PROC_STATE 5'h0c
`define SCRB_NUM_EXC_REASON 5'h0d
`define SCRB_NUM_EXC_RETURN_PC 5'h0e
`define SCRB_NUM_PROC_IDENTITY 5'h0f
`define SCRB_NUM_CONFIGURATION 5'h10
`define SCRB_NUM_LINKED_LOAD 5'h11
`define SCRB_NUM_WATCH_LOW 5'h12
`define SCRB_NUM_WATCH_HIGH 5'h13
`define SCRB_NUM_DEBUG_CONTROL 5'h17
`define SCRB_NUM_DEBUG_RETURN_PC 5'h18
`define SCRB_NUM_ARRAY_ACCESS 5'h1a
`define SCRB_NUM_CACHE_TAG_LOW 5'h1c
`define SCRB_NUM_ERROR_RETURN_PC 5'h1e
`define SCRB_NUM_DEBUG_SCRATCH 5'h1f

// select codes; the second configuration word shares number 16
`define SCRB_SEL_PRIMARY 3'h0
`define SCRB_SEL_CONFIG1 3'h1

// storage slots: 0..31 follow the number, 32 is configuration select 1
`define SCRB_SLOT_CONFIG1 6'h20
`define SCRB_SLOT_NONE 6'h21

// field masks of the documented layouts
`define SCRB_ALL_ONES 32'hffff_ffff
`define SCRB_INDEX_SW_MASK 32'h0000_000f
`define SCRB_INDEX_ZERO_MASK 32'h7fff_fff0
`define SCRB_RANDOM_HW_MASK 32'h0000_000f
`define SCRB_RANDOM_ZERO_MASK 32'hffff_fff0
`define SCRB_RANDOM_RST_VAL 32'h0000_000f
`define SCRB_ENTRY_LOW_SW_MASK 32'h3fff_ffff
`define SCRB_ENTRY_LOW_ZERO_MASK 32'hc000_0000
`define SCRB_ENTRY_LOW_RST_MASK 32'hfc00_0000
`define SCRB_ENTRY_LOW_RST_VAL 32'h0000_0000
`define SCRB_RANDOM_TOP 4'hf

`endif

// [rtl/scrb_pkg.sv]
// types shared by the control register bank and its storage cell
// assumes: scrb_regs.svh holds every number used here
`default_nettype none

package scrb_pkg;

	// one privileged move-to / move-from request
	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] num;
		logic [2:0] sel;
		logic [31:0] data;
	} scrb_req_t;

	// an update that the core's own logic places into a register
	typedef struct packed {
		logic valid;
		logic [4:0] num;
		logic [2:0] sel;
		logic [31:0] mask;
		logic [31:0] data;
	} scrb_hwupd_t;

	typedef struct packed {
		logic [31:0] value;
	} scrb_cell_state_t;

	typedef struct packed {
		logic rdValid;
		logic [31:0] rdData;
	} scrb_bank_state_t;

endpackage

`default_nettype wire

// [rtl/scrb_field_reg.sv]
// one 32-bit control register with per-bit access classes
// assumes: write strobes are single-cycle and synchronous to mclk
`default_nettype none
`include "scrb_regs.svh"

module scrb_field_reg #(
	parameter logic [31:0] SW_MASK = 32'hffff_ffff,
	parameter logic [31:0] ZERO_MASK = 32'h0000_0000,
	parameter logic [31:0] RST_MASK = 32'h0000_0000,
	parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// software side
	input wire logic swWe,
	input wire logic [31:0] swData,
	// hardware side
	input wire logic hwWe,
	input wire logic [31:0] hwMask,
	input wire logic [31:0] hwData,
	// stored word
	output logic [31:0] value
);
	import scrb_pkg::*;

	scrb_cell_state_t state_r;
	scrb_cell_state_t state_nxt;

	always_comb
	begin
		state_nxt = state_r;
		// software touches only its writable bits, the rest ignore it
		if (swWe)
		begin
			state_nxt.value = (state_r.value & ~SW_MASK) | (swData & SW_MASK);
		end
		// a hardware update in the same cycle wins on its own bits
		if (hwWe)
		begin
			state_nxt.value = (state_nxt.value & ~hwMask) | (hwData & hwMask);
		end
		state_nxt.value = state_nxt.value & ~ZERO_MASK;
		// bits without a defined reset keep whatever they held
		if (srst)
		begin
			state_nxt.value = (state_r.value & ~RST_MASK) | (RST_VAL & RST_MASK);
		end
	end

	always_ff @(posedge mclk)
	begin
		state_r <= state_nxt;
	end

	assign value = state_r.value;

endmodule

`default_nettype wire

// [rtl/scrb_bank.sv]
// system control register bank: 32 register numbers, 25 implemented with the translation unit, plus select 1 of 16
// assumes: one request per cycle from the core, reads answered next cycle
//
// Function
// [R1] Register numbers 0 to 31 each pick one fixed control register.
// [R2] Numbers 0 to 6 and 10 exist only with the translation unit.
// [R3] A select field picks among several registers at one number, as 16.
// [R4] Read/write fields take software and hardware updates, each visible.
// [R5] Undefined read/write fields must be initialised before relying on reads.
// [R6] Hardware-only fields ignore software writes and read hardware's last value.
// [R7] Hardware-only fields with zero or preset reset take that value at reset.
// [R8] Undefined hardware-only fields change only under their own conditions.
// [R9] Must-be-zero bits are never updated and read back as zero.
// [R10] Software always writes zero into must-be-zero bits.
// [R11] Software writes zero before relying on undefined must-be-zero bits.
// [R12] A register write may take some instructions to show its effect.
// [R13] Words are 32 bits; reserved numbers read zero and ignore writes.
`default_nettype none
`include "scrb_regs.svh"

module scrb_bank #(
	parameter bit TLB_PRESENT = 1'b1,
	// identity word, value is arbitrary
	parameter logic [31:0] IDENTITY = 32'h0000_0101
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// move-to / move-from requests
	input wire scrb_pkg::scrb_req_t req,
	// updates from the core's own logic
	input wire scrb_pkg::scrb_hwupd_t hwUpd,
	// read answer
	output logic rdValid,
	output logic [31:0] rdData
);
	import scrb_pkg::*;

	// map number and select onto a storage slot
	function automatic logic [5:0] slotOf(input logic [4:0] num,
		input logic [2:0] sel);
		logic [5:0] slot;
		slot = `SCRB_SLOT_NONE;
		if (sel == `SCRB_SEL_PRIMARY)
		begin
			slot = {1'b0, num}; // R1
		end
		else if (sel == `SCRB_SEL_CONFIG1 && num == `SCRB_NUM_CONFIGURATION)
		begin
			slot = `SCRB_SLOT_CONFIG1; // R3
		end
		return slot;
	endfunction

	// slots with real storage; the rest are reserved
	function automatic logic implemented(input logic [5:0] slot);
		logic ok;
		ok = 1'b1;
		if (slot == `SCRB_SLOT_NONE)
		begin
			ok = 1'b0;
		end
		else if (slot == 6'h07 || slot == 6'h14 || slot == 6'h15 ||
			slot == 6'h16 || slot == 6'h19 || slot == 6'h1b ||
			slot == 6'h1d)
		begin
			ok = 1'b0; // R13
		end
		else if (!TLB_PRESENT && (slot <= 6'h06 || slot == 6'h0a))
		begin
			ok = 1'b0; // R2
		end
		return ok;
	endfunction

	function automatic logic [31:0] swMaskOf(input int slot);
		logic [31:0] m;
		m = `SCRB_ALL_ONES;
		if (slot == `SCRB_NUM_TLB_INDEX)
		begin
			m = `SCRB_INDEX_SW_MASK;
		end
		else if (slot == `SCRB_NUM_TLB_RANDOM ||
			slot == `SCRB_NUM_PROC_IDENTITY)
		begin
			m = 32'h0000_0000; // R6
		end
		else if (slot == `SCRB_NUM_ENTRY_LOW_EVEN ||
			slot == `SCRB_NUM_ENTRY_LOW_ODD)
		begin
			m = `SCRB_ENTRY_LOW_SW_MASK;
		end
		return m;
	endfunction

	function automatic logic [31:0] zeroMaskOf(input int slot);
		logic [31:0] m;
		m = 32'h0000_0000;
		if (slot == `SCRB_NUM_TLB_INDEX)
		begin
			m = `SCRB_INDEX_ZERO_MASK;
		end
		else if (slot == `SCRB_NUM_TLB_RANDOM)
		begin
			m = `SCRB_RANDOM_ZERO_MASK;
		end
		else if (slot == `SCRB_NUM_ENTRY_LOW_EVEN ||
			slot == `SCRB_NUM_ENTRY_LOW_ODD)
		begin
			m = `SCRB_ENTRY_LOW_ZERO_MASK;
		end
		return m;
	endfunction

	function automatic logic [31:0] rstMaskOf(input int slot);
		logic [31:0] m;
		m = 32'h0000_0000;
		if (slot == `SCRB_NUM_TLB_INDEX)
		begin
			m = `SCRB_INDEX_ZERO_MASK;
		end
		else if (slot == `SCRB_NUM_TLB_RANDOM ||
			slot == `SCRB_NUM_PROC_IDENTITY)
		begin
			m = `SCRB_ALL_ONES;
		end
		else if (slot == `SCRB_NUM_ENTRY_LOW_EVEN ||
			slot == `SCRB_NUM_ENTRY_LOW_ODD)
		begin
			m = `SCRB_ENTRY_LOW_RST_MASK;
		end
		return m;
	endfunction

	function automatic logic [31:0] rstValOf(input int slot);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (slot == `SCRB_NUM_TLB_RANDOM)
		begin
			v = `SCRB_RANDOM_RST_VAL;
		end
		else if (slot == `SCRB_NUM_PROC_IDENTITY)
		begin
			v = IDENTITY;
		end
		else if (slot == `SCRB_NUM_ENTRY_LOW_EVEN ||
			slot == `SCRB_NUM_ENTRY_LOW_ODD)
		begin
			v = `SCRB_ENTRY_LOW_RST_VAL;
		end
		return v;
	endfunction

	scrb_bank_state_t state_r;
	scrb_bank_state_t state_nxt;
	logic [31:0] word [0:32];
	logic [5:0] reqSlot;
	logic [5:0] hwSlot;
	logic reqOk;
	logic swWrite;
	logic hwValid;
	logic wiredWrite;
	logic [3:0] randomNxt;
	logic [31:0] countNxt;

	assign reqSlot = slotOf(req.num, req.sel);
	assign hwSlot = slotOf(hwUpd.num, hwUpd.sel);
	assign reqOk = implemented(reqSlot);
	assign swWrite = req.valid && req.write && reqOk; // R13
	assign hwValid = hwUpd.valid && implemented(hwSlot);
	assign wiredWrite = swWrite && reqSlot == {1'b0, `SCRB_NUM_FIXED_ENTRY_CNT};

	// random index walks down to the fixed-entry bound, then wraps to the top;
	// a write of the fixed-entry count restarts it from the top
	always_comb
	begin
		randomNxt = word[`SCRB_NUM_TLB_RANDOM][3:0] - 4'h1;
		if (wiredWrite ||
			word[`SCRB_NUM_TLB_RANDOM][3:0] == word[`SCRB_NUM_FIXED_ENTRY_CNT][3:0])
		begin
			randomNxt = `SCRB_RANDOM_TOP;
		end
	end

	assign countNxt = word[`SCRB_NUM_CYCLE_COUNTER] + 32'h0000_0001;

	genvar g;
	generate
		for (g = 0; g <= 32; g++)
		begin : gSlot
			// reserved slots get no strobes, so nothing is left undriven
			if (implemented(6'(g)))
			begin : gCell
				logic cellSwWe;
				logic cellHwWe;
				logic [31:0] cellHwMask;
				logic [31:0] cellHwData;
				always_comb
				begin
					cellSwWe = swWrite && reqSlot == 6'(g);
					cellHwWe = hwValid && hwSlot == 6'(g);
					cellHwMask = hwUpd.mask;
					cellHwData = hwUpd.data;
					if (g == `SCRB_NUM_TLB_RANDOM)
					begin
						cellHwWe = 1'b1;
						cellHwMask = `SCRB_RANDOM_HW_MASK; // R8
						cellHwData = {28'h000_0000, randomNxt};
					end
					else if (g == `SCRB_NUM_CYCLE_COUNTER && !cellHwWe &&
						!cellSwWe)
					begin
						// a software load takes this cycle instead of a tick
						cellHwWe = 1'b1; // R4
						cellHwMask = `SCRB_ALL_ONES;
						cellHwData = countNxt;
					end
				end
				scrb_field_reg #(
					.SW_MASK(swMaskOf(g)),
					.ZERO_MASK(zeroMaskOf(g)),
					.RST_MASK(rstMaskOf(g)),
					.RST_VAL(rstValOf(g))
				) uCell (
					.mclk(mclk),
					.srst(srst),
					.swWe(cellSwWe),
					.swData(req.data),
					.hwWe(cellHwWe),
					.hwMask(cellHwMask),
					.hwData(cellHwData),
					.value(word[g])
				);
			end
			else
			begin : gReserved
				assign word[g] = 32'h0000_0000; // R13
			end
		end
	endgenerate

	// reads are registered so the answer comes from a flop, one cycle later
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.rdValid = req.valid && !req.write;
		state_nxt.rdData = 32'h0000_0000;
		if (req.valid && !req.write && reqOk)
		begin
			state_nxt.rdData = word[reqSlot]; // R1 R12
		end
		if (srst)
		begin
			state_nxt = '0;
		end
	end

	always_ff @(posedge mclk)
	begin
		state_r <= state_nxt;
	end

	assign rdValid = state_r.rdValid;
	assign rdData = state_r.rdData;

	rd_latency_a: assert property (@(posedge mclk) disable iff (srst) // R1
		req.valid && !req.write |=> rdValid)
		else $error("read request not answered in one cycle");

	rsvd_read_a: assert property (@(posedge mclk) disable iff (srst) // R13
		req.valid && !req.write && req.num == 5'h07 |=> rdData == 32'h0)
		else $error("reserved register read nonzero");

	tlb_absent_a: assert property (@(posedge mclk) disable iff (srst) // R2
		!TLB_PRESENT && req.valid && !req.write &&
		req.num == `SCRB_NUM_ENTRY_HIGH |=> rdData == 32'h0)
		else $error("translation register present without unit");

	sel_split_a: assert property (@(posedge mclk) disable iff (srst) // R3
		req.valid && !req.write && req.num == `SCRB_NUM_CONFIGURATION &&
		req.sel > `SCRB_SEL_CONFIG1 |=> rdData == 32'h0)
		else $error("unused select of configuration read nonzero");

	sw_visible_a: assert property (@(posedge mclk) disable iff (srst) // R4
		req.valid && req.write && req.num == `SCRB_NUM_TIMER_MATCH &&
		req.sel == 3'h0 && !hwUpd.valid ##1
		req.valid && !req.write && req.num == `SCRB_NUM_TIMER_MATCH &&
		req.sel == 3'h0 |=> rdData == $past(req.data, 2))
		else $error("software write not read back");

	hw_only_a: assert property (@(posedge mclk) disable iff (srst) // R6
		req.valid && req.write && req.num == `SCRB_NUM_PROC_IDENTITY &&
		!hwUpd.valid |=> word[`SCRB_NUM_PROC_IDENTITY] ==
		$past(word[`SCRB_NUM_PROC_IDENTITY]))
		else $error("software changed a hardware-only register");

	rst_preset_a: assert property (@(posedge mclk) // R7
		$fell(srst) |-> word[`SCRB_NUM_TLB_RANDOM] ==
		(TLB_PRESENT ? `SCRB_RANDOM_RST_VAL : 32'h0000_0000) &&
		word[`SCRB_NUM_PROC_IDENTITY] == IDENTITY)
		else $error("preset value missing after reset");

	rand_wrap_a: assert property (@(posedge mclk) disable iff (srst) // R8
		wiredWrite |=> word[`SCRB_NUM_TLB_RANDOM][3:0] == `SCRB_RANDOM_TOP)
		else $error("random index not restarted by fixed-count write");

	mbz_zero_a: assert property (@(posedge mclk) disable iff (srst) // R9
		req.valid && req.write && req.num == `SCRB_NUM_TLB_INDEX &&
		req.sel == 3'h0 |=> word[`SCRB_NUM_TLB_INDEX][30:4] == 27'h0)
		else $error("must-be-zero bits took a written value");

	count_tick_a: assert property (@(posedge mclk) disable iff (srst) // R4
		!(req.valid && req.write && req.num == `SCRB_NUM_CYCLE_COUNTER) &&
		!(hwUpd.valid && hwUpd.num == `SCRB_NUM_CYCLE_COUNTER) |=>
		word[`SCRB_NUM_CYCLE_COUNTER] ===
		$past(word[`SCRB_NUM_CYCLE_COUNTER]) + 32'h0000_0001)
		else $error("cycle counter did not advance");

	// a clash on one word must leave hardware's bits, not software's
	hw_wins_a: assert property (@(posedge mclk) disable iff (srst) // R4
		req.valid && req.write && req.num == `SCRB_NUM_TIMER_MATCH &&
		req.sel == 3'h0 && hwUpd.valid &&
		hwUpd.num == `SCRB_NUM_TIMER_MATCH && hwUpd.sel == 3'h0 |=>
		(word[`SCRB_NUM_TIMER_MATCH] & $past(hwUpd.mask)) ==
		($past(hwUpd.data) & $past(hwUpd.mask)))
		else $error("hardware update lost to a software write");

	count_load_a: assert property (@(posedge mclk) disable iff (srst) // R4
		req.valid && req.write && req.num == `SCRB_NUM_CYCLE_COUNTER &&
		req.sel == 3'h0 && !hwUpd.valid |=>
		word[`SCRB_NUM_CYCLE_COUNTER] == $past(req.data))
		else $error("cycle counter load lost");

	// an unset fixed-entry count is unknown, which keeps this one quiet
	rand_step_a: assert property (@(posedge mclk) disable iff (srst) // R8
		!wiredWrite && word[`SCRB_NUM_TLB_RANDOM][3:0] !=
		word[`SCRB_NUM_FIXED_ENTRY_CNT][3:0] |=>
		word[`SCRB_NUM_TLB_RANDOM][3:0] ==
		$past(word[`SCRB_NUM_TLB_RANDOM][3:0]) - 4'h1)
		else $error("random index skipped a step");

	cfg_sel_a: assert property (@(posedge mclk) disable iff (srst) // R3
		req.valid && req.write && req.num == `SCRB_NUM_CONFIGURATION &&
		req.sel == `SCRB_SEL_CONFIG1 && !hwUpd.valid |=>
		word[`SCRB_NUM_CONFIGURATION] ==
		$past(word[`SCRB_NUM_CONFIGURATION]))
		else $error("second configuration write hit the first");

	idx_probe_a: assert property (@(posedge mclk) disable iff (srst) // R6
		req.valid && req.write && req.num == `SCRB_NUM_TLB_INDEX &&
		!hwUpd.valid |=> word[`SCRB_NUM_TLB_INDEX][31] ==
		$past(word[`SCRB_NUM_TLB_INDEX][31]))
		else $error("software changed the probe bit");

endmodule

`default_nettype wire

// [test/test_scrb_bank.sv]
// self-checking bench for the control register bank, both variants
// assumes: scrb_pkg is compiled first; the bench alone drives the bank
`default_nettype none

module test_scrb_bank import scrb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	// identity word, value is arbitrary
	localparam logic [31:0] IDENT = 32'h0000_0a5c;

	logic mclk;
	logic srst;
	scrb_req_t req;
	scrb_hwupd_t hwUpd;
	logic rdValid;
	logic [31:0] rdData;
	logic rdValid2;
	logic [31:0] rdData2;
	int fails;
	int numChecks;
	int seed;
	logic [31:0] mem [0:32];
	logic wiredSet;
	logic expValid;
	logic rndChk;
	logic [31:0] expData;
	logic [31:0] expData2;
	logic [31:0] cmpMask;
	logic [31:0] readMask;
	logic [31:0] hm;
	logic [4:0] num;
	logic [2:0] sel;
	logic rstReq;

	scrb_bank #(.TLB_PRESENT(1'b1), .IDENTITY(IDENT)) DUT (
		.mclk(mclk), .srst(srst), .req(req), .hwUpd(hwUpd),
		.rdValid(rdValid), .rdData(rdData));
	scrb_bank #(.TLB_PRESENT(1'b0), .IDENTITY(IDENT)) dutNoTlb (
		.mclk(mclk), .srst(srst), .req(req), .hwUpd(hwUpd),
		.rdValid(rdValid2), .rdData(rdData2));

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// 33 stands for every reserved number or select
	function automatic int slotOf(input logic [4:0] n, input logic [2:0] s);
		if (s == 3'h1 && n == 5'h10)
			return 32;
		if (s != 3'h0 || n inside {5'h07, 5'h14, 5'h15, 5'h16, 5'h19,
			5'h1b, 5'h1d})
			return 33;
		return int'(n);
	endfunction

	function automatic logic [31:0] swMask(input int sl);
		case (sl)
			0: return 32'h0000_000f;
			1, 15, 33: return 32'h0000_0000;
			2, 3: return 32'h3fff_ffff;
			default: return 32'hffff_ffff;
		endcase
	endfunction

	// bits that software must write as zero
	function automatic logic [31:0] mustZero(input int sl);
		case (sl)
			0: return 32'h7fff_fff0;
			1: return 32'hffff_fff0;
			2, 3: return 32'hfc00_0000;
			default: return 32'h0000_0000;
		endcase
	endfunction

	// one request per negedge; the previous request's answer is checked first
	task automatic step(input int op, input logic [4:0] n,
		input logic [2:0] s, input logic [31:0] d, input logic hv,
		input logic [31:0] hmask, input logic [31:0] hd);
		int sl;
		logic [31:0] wd;
		sl = slotOf(n, s);
		wd = (sl == 33) ? d : d & ~mustZero(sl);
		@(negedge mclk);
		check({31'h0, rdValid}, {31'h0, expValid});
		check({31'h0, rdValid2}, {31'h0, expValid});
		check(rdData & cmpMask, expData & cmpMask);
		check(rdData2 & cmpMask, expData2 & cmpMask);
		if (rndChk)
			check({31'h0, rdData[3:0] >= mem[6][3:0]}, 32'h0000_0001);
		// reset moves with the request, so the model sees the same edge
		srst = rstReq;
		req = '{op != 0, op == 2, n, s, wd};
		hwUpd = '{hv, n, 3'h0, hmask, hd};
		expValid = op == 1 && !srst;
		cmpMask = readMask;
		rndChk = 1'b0;
		expData = 32'h0000_0000;
		expData2 = 32'h0000_0000;
		if (expValid)
		begin
			expData = (sl == 33) ? 32'h0000_0000 : mem[sl];
			if (sl == 1)
			begin
				expData = 32'h0000_0000;
				cmpMask = 32'hffff_fff0;
				rndChk = wiredSet;
			end
			expData2 = (s == 3'h0 && (n <= 5'h06 || n == 5'h0a)) ?
				32'h0000_0000 : expData;
		end
		// a load by either side replaces the tick; reset freezes the count
		if (!srst && !(op == 2 && sl == 9) && !(hv && n == 5'h09))
			mem[9] = mem[9] + 32'h0000_0001;
		if (srst)
			mem[15] = IDENT;
		if (!srst && op == 2 && sl < 33)
			mem[sl] = (mem[sl] & ~swMask(sl)) | (wd & swMask(sl));
		// hardware lands after software, so it wins on its mask bits
		if (!srst && hv && !(slotOf(n, 3'h0) inside {1, 6, 33}))
			mem[n] = (mem[n] & ~hmask) | (hd & hmask);
		if (!srst && op == 2 && sl == 6)
			wiredSet = 1'b1;
	endtask

	initial
	begin
		seed = 32'h1f41;
		fails = 0;
		numChecks = 0;
		srst = 1'b1;
		req = '0;
		hwUpd = '0;
		expValid = 1'b0;
		rndChk = 1'b0;
		wiredSet = 1'b0;
		expData = 32'h0000_0000;
		expData2 = 32'h0000_0000;
		cmpMask = 32'hffff_ffff;
		readMask = 32'hffff_ffff;
		foreach (mem[i])
			mem[i] = 32'hxxxx_xxxx;
		rstReq = 1'b0;
		mem[0][30:4] = 27'h000_0000;
		mem[15] = IDENT;
		mem[2][31:26] = 6'h00;
		mem[3][31:26] = 6'h00;
		repeat (5) @(negedge mclk);
		srst = 1'b0;
		for (int r = 0; r < 2; r++)
		begin
			step(1, 5'h0f, 3'h0, 32'h0000_0000, 1'b0, 32'h0, 32'h0);
			step(2, 5'h0f, 3'h0, $random(seed), 1'b0, 32'h0, 32'h0);
			step(1, 5'h0f, 3'h0, 32'h0000_0000, 1'b0, 32'h0, 32'h0);
			readMask = 32'hfc00_0000;
			step(1, 5'h02, 3'h0, 32'h0000_0000, 1'b0, 32'h0, 32'h0);
			step(1, 5'h03, 3'h0, 32'h0000_0000, 1'b0, 32'h0, 32'h0);
			readMask = 32'hffff_ffff;
			step(1, 5'h01, 3'h0, 32'h0000_0000, 1'b0, 32'h0, 32'h0);
			if (r == 1)
				break;
			// probe bit of the index comes from hardware only
			step(0, 5'h00, 3'h0, 32'h0, 1'b1, 32'h8000_000f, $random(seed));
			for (int pass = 0; pass < 3; pass++)
				for (int k = 0; k < 34; k++)
				begin
					num = (k < 32) ? k[4:0] : 5'h10;
					sel = (k == 32) ? 3'h1 : (k == 33) ? 3'h2 : 3'h0;
					hm = $random(seed) & ~mustZero(slotOf(num, 3'h0));
					step(2, num, sel, $random(seed), pass > 0 && num != 5'h06,
						hm, $random(seed));
					step(1, num, sel, 32'h0, 1'b0, 32'h0, 32'h0);
				end
			step(0, 5'h08, 3'h0, 32'h0, 1'b1, 32'h0000_ffff, $random(seed));
			step(1, 5'h08, 3'h0, 32'h0, 1'b0, 32'h0, 32'h0);
			step(1, 5'h0c, 3'h0, 32'h0, 1'b0, 32'h0, 32'h0);
			// a reset in mid-run refuses the request it overlaps
			rstReq = 1'b1;
			step(1, 5'h0c, 3'h0, 32'h0, 1'b0, 32'h0, 32'h0);
			step(0, 5'h00, 3'h0, 32'h0, 1'b0, 32'h0, 32'h0);
			rstReq = 1'b0;
		end
		step(0, 5'h00, 3'h0, 32'h0, 1'b0, 32'h0, 32'h0);
		tally_and_finish();
	end

	// the whole sequence needs well under 5000 cycles
	initial
	begin
		#50000;
		fails++;
		tally_and_finish();
	end
endmodule

`default_nettype wire
